/* verilog/slp_consts.svh */
// Register offsets, field positions, reset values and timing counts of the sleep controller
`ifndef SLP_CONSTS_SVH
`define SLP_CONSTS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define SLP_OFS_CTRL        8'h00
`define SLP_OFS_STATUS      8'h04
`define SLP_OFS_COUNT       8'h08
`define SLP_OFS_COMPARE0    8'h0c
`define SLP_OFS_IRQ_STATUS  8'h10
`define SLP_OFS_IRQ_CLEAR   8'h14
`define SLP_OFS_IRQ_ENABLE  8'h18

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define SLP_CTRL_CNT_EN     0
`define SLP_CTRL_CMP_TOP    1
`define SLP_CTRL_DEEP_SEL   2
`define SLP_CTRL_RCO_EN     3
`define SLP_CTRL_XO_EN      4
`define SLP_CTRL_CNT_CLK    5
`define SLP_CTRL_LE_CLK     6
`define SLP_CTRL_WIDTH      7
`define SLP_CTRL_RESET      7'h00

// Status register fields
`define SLP_STAT_STATE_LO   0
`define SLP_STAT_RCO_RDY    2
`define SLP_STAT_XO_RDY     3

// Interrupt bit positions
`define SLP_IRQ_CMP0        0
`define SLP_IRQ_WAKE        1
`define SLP_IRQ_WIDTH       2
`define SLP_IRQ_RESET       2'h0

// Counter
`define SLP_CNT_WIDTH       24
`define SLP_CNT_RESET       24'h000000

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define SLP_CORE_HZ         25'd25000000
`define SLP_LF_HZ           25'd32768
`define SLP_CLK_PERIOD_NS   32'd40
`define SLP_OSC_START_NS    32'd10000
`define SLP_OSC_START_CYC   ((`SLP_OSC_START_NS + `SLP_CLK_PERIOD_NS - 32'd1) / `SLP_CLK_PERIOD_NS)

`endif

/* verilog/slp_pkg.sv */
// Types shared by the sleep controller files
package slp_pkg;
  typedef enum logic [1:0] {
    SLP_ACTIVE   = 2'b00,
    SLP_LIGHT    = 2'b01,
    SLP_DEEP_RUN = 2'b10,
    SLP_DEEP_OFF = 2'b11
  } slp_state_type;
endpackage

/* verilog/slp_lf_tick.sv */
// Fractional divider making the low-frequency counter tick from the core clock
`timescale 1ns/1ps
`include "slp_consts.svh"
module slp_lf_tick (
  input  wire logic clk_i,   // Core clock
  input  wire logic rst_i,   // Synchronous reset
  input  wire logic run_i,   // Counter running: both module clocks, count enable and an oscillator on
  output logic      tick_o   // One-cycle tick at the low-frequency rate
);
  logic [24:0] acc;
  wire  [25:0] acc_sum = {1'b0, acc} + {1'b0, `SLP_LF_HZ};
  wire         wrap    = acc_sum >= {1'b0, `SLP_CORE_HZ};
  wire  [24:0] next_acc = wrap ? 25'(acc_sum - {1'b0, `SLP_CORE_HZ}) : acc_sum[24:0];

  // Phase accumulator keeps the long-term rate exact, at the cost of one cycle of jitter
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      acc    <= 25'h0000000;
      tick_o <= 1'b0;
    end else begin
      acc    <= next_acc;
      tick_o <= wrap;
    end
  end
endmodule // slp_lf_tick

/* verilog/slp_sleep_ctrl.sv */
// Sleep depth controller with low-frequency wake-up counter and Wishbone registers
`timescale 1ns/1ps
`include "slp_consts.svh"

// Contract
// [R1] Sleep request with deep select clear enters light sleep, fast clock kept.
// [R2] Sleep request, deep select set, a low-frequency oscillator on: deep sleep, running.
// [R3] Sleep request, deep select set, all low-frequency oscillators off: deepest sleep.
// [R4] During debug any sleep request only reaches light sleep.
// [R5] Software enables the RC oscillator and waits for ready before deep sleep.
// [R6] Software enables counter clock and interface clock before counter register access.
// [R7] Compare-zero flag sets when the count becomes equal to compare register zero.
// [R8] Counter advances at 32.768 kHz; five seconds is a compare of 163840.
// [R9] Interrupt requested only when compare-zero flag and its enable are both set; the code also requests it for the wake flag with its enable.
// [R10] The core's interrupt controller must enable the counter interrupt line.
// [R11] Interrupt stays asserted until the flag is cleared by the handler; the code also drops it when its enable is cleared.
// [R12] Writes ignored and reads zero while module clock is off; clocks off after reset.
// [R13] With compare-zero as top the count wraps to zero after the match.
// [R14] Counter keeps running in deep sleep; its interrupt wakes the core.
module slp_sleep_ctrl
  import slp_pkg::*;
(
  input  wire logic        clk_i,                      // Core clock, 25 MHz
  input  wire logic        rst_i,                      // Synchronous reset, active high
  input  wire logic        wb_cyc_i,                   // Wishbone cycle
  input  wire logic        wb_stb_i,                   // Wishbone strobe
  input  wire logic        wb_we_i,                    // Wishbone write enable
  input  wire logic [7:0]  wb_adr_i,                   // Wishbone byte address
  input  wire logic [3:0]  wb_sel_i,                   // Wishbone byte selects
  input  wire logic [31:0] wb_dat_i,                   // Wishbone write data
  output logic      [31:0] wb_dat_o,                   // Wishbone read data
  output logic             wb_ack_o,                   // Wishbone acknowledge
  input  wire logic        wait_for_interrupt_instr_i, // Core sleep request pulse
  input  wire logic        debug_active_i,             // Debug session active
  output logic      [1:0]  sleep_state_o,              // Current sleep depth
  output logic             core_halted_o,              // Core halted
  output logic             hf_clock_on_o,              // High-frequency clock running
  output logic             irq_o                       // Level interrupt request
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [`SLP_CTRL_WIDTH-1:0] ctrl;
  logic [`SLP_CNT_WIDTH-1:0]  count;
  logic [`SLP_CNT_WIDTH-1:0]  compare0;
  logic [`SLP_IRQ_WIDTH-1:0]  irq_status;
  logic [`SLP_IRQ_WIDTH-1:0]  irq_enable;
  logic [31:0]                rco_timer;
  logic                       rco_ready;
  logic                       xo_ready;
  logic                       lf_tick;
  logic                       tick_d;
  slp_state_type              state;
  slp_state_type              next_state;

  // Merge write data into a register under the byte selects
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire bus_wr    = bus_req && wb_we_i;
  // Counter block is reachable only with both its clocks on
  wire mod_clk   = ctrl[`SLP_CTRL_CNT_CLK] && ctrl[`SLP_CTRL_LE_CLK]; // R6
  wire sel_ctrl  = wb_adr_i == `SLP_OFS_CTRL;
  wire sel_stat  = wb_adr_i == `SLP_OFS_STATUS;
  wire sel_cnt   = wb_adr_i == `SLP_OFS_COUNT;
  wire sel_cmp   = wb_adr_i == `SLP_OFS_COMPARE0;
  wire sel_ist   = wb_adr_i == `SLP_OFS_IRQ_STATUS;
  wire sel_icl   = wb_adr_i == `SLP_OFS_IRQ_CLEAR;
  wire sel_ien   = wb_adr_i == `SLP_OFS_IRQ_ENABLE;
  wire wr_ctrl   = bus_wr && sel_ctrl;
  wire wr_cmp    = bus_wr && sel_cmp && mod_clk; // R12
  wire wr_icl    = bus_wr && sel_icl && mod_clk; // R12
  wire wr_ien    = bus_wr && sel_ien && mod_clk; // R12

  wire [31:0] ctrl_ext = {25'h0000000, ctrl};
  wire [31:0] stat_ext = {28'h0000000, xo_ready, rco_ready, state};
  wire [31:0] cnt_ext  = {8'h00, count};
  wire [31:0] cmp_ext  = {8'h00, compare0};
  wire [31:0] ist_ext  = {30'h00000000, irq_status};
  wire [31:0] ien_ext  = {30'h00000000, irq_enable};
  wire [31:0] next_ctrl_w = merge(ctrl_ext, wb_dat_i, wb_sel_i);
  wire [31:0] next_cmp_w  = merge(cmp_ext, wb_dat_i, wb_sel_i);
  wire [31:0] next_ien_w  = merge(ien_ext, wb_dat_i, wb_sel_i);
  wire [31:0] icl_w       = merge(32'h00000000, wb_dat_i, wb_sel_i);

  // Gated counter registers read as zero while the module clock is off
  wire [31:0] rd_data =
      sel_ctrl            ? ctrl_ext :
      sel_stat            ? stat_ext :
      (sel_cnt && mod_clk) ? cnt_ext :  // R12
      (sel_cmp && mod_clk) ? cmp_ext :  // R12
      (sel_ist && mod_clk) ? ist_ext :  // R12
      (sel_ien && mod_clk) ? ien_ext :  // R12
      32'h00000000;

  // ---------------------------------------------------------------
  // Wishbone slave: one wait state, every address answered
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_data : 32'h00000000;
    end
  end

  // Control register; all module clocks start disabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `SLP_CTRL_RESET; // R12
    end else if (wr_ctrl) begin
      ctrl <= next_ctrl_w[`SLP_CTRL_WIDTH-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Oscillator readiness
  // ---------------------------------------------------------------
  wire rco_on = ctrl[`SLP_CTRL_RCO_EN];
  wire xo_on  = ctrl[`SLP_CTRL_XO_EN];
  wire lf_on  = rco_on || xo_on;

  // Ready after the startup time counted from the first oscillator enabled (one shared timer); software is expected to poll it
  always_ff @(posedge clk_i) begin
    if (rst_i || !lf_on) begin
      rco_timer <= 32'h00000000;
      rco_ready <= 1'b0;
      xo_ready  <= 1'b0;
    end else if (rco_timer < `SLP_OSC_START_CYC) begin
      rco_timer <= rco_timer + 32'h00000001;
    end else begin
      rco_ready <= rco_on; // R5
      xo_ready  <= xo_on;
    end
  end

  // ---------------------------------------------------------------
  // Low-frequency counter
  // ---------------------------------------------------------------
  wire cnt_run   = mod_clk && ctrl[`SLP_CTRL_CNT_EN] && lf_on; // R14
  wire cmp_match = count == compare0;
  wire cmp_set   = tick_d && cmp_match;
  wire next_wrap = ctrl[`SLP_CTRL_CMP_TOP] && cmp_match;
  wire [`SLP_CNT_WIDTH-1:0] next_count = next_wrap ? `SLP_CNT_RESET : count + 24'h000001;

  slp_lf_tick u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (cnt_run),
    .tick_o (lf_tick)
  );

  // Count advances on each low-frequency tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count  <= `SLP_CNT_RESET;
      tick_d <= 1'b0;
    end else begin
      tick_d <= lf_tick && cnt_run;
      if (lf_tick && cnt_run) begin
        count <= next_count; // R8 R13
      end
    end
  end

  // Compare register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare0 <= `SLP_CNT_RESET;
    end else if (wr_cmp) begin
      compare0 <= next_cmp_w[`SLP_CNT_WIDTH-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Interrupts: sticky status, write-one clear, set wins over clear
  // ---------------------------------------------------------------
  wire wake_set = (state != SLP_ACTIVE) && (next_state == SLP_ACTIVE);
  wire [`SLP_IRQ_WIDTH-1:0] irq_set   = {wake_set, cmp_set}; // R7
  wire [`SLP_IRQ_WIDTH-1:0] irq_clr   = wr_icl ? icl_w[`SLP_IRQ_WIDTH-1:0] : `SLP_IRQ_RESET;
  wire [`SLP_IRQ_WIDTH-1:0] next_ist  = (irq_status & ~irq_clr) | irq_set; // R11
  wire                      irq_pend  = |(irq_status & irq_enable); // R9

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= `SLP_IRQ_RESET;
      irq_enable <= `SLP_IRQ_RESET;
      irq_o      <= 1'b0;
    end else begin
      irq_status <= next_ist;
      if (wr_ien) begin
        irq_enable <= next_ien_w[`SLP_IRQ_WIDTH-1:0];
      end
      irq_o <= irq_pend; // R9 R11
    end
  end

  // ---------------------------------------------------------------
  // Sleep state machine
  // ---------------------------------------------------------------
  // Debug keeps the fast clock alive, so deep requests fall back to light
  wire want_deep = ctrl[`SLP_CTRL_DEEP_SEL] && !debug_active_i; // R4

  always_comb begin
    next_state = state;
    case (state)
      SLP_ACTIVE: begin
        if (wait_for_interrupt_instr_i) begin
          if (!want_deep) begin
            next_state = SLP_LIGHT; // R1 R4
          end else if (lf_on) begin
            next_state = SLP_DEEP_RUN; // R2
          end else begin
            next_state = SLP_DEEP_OFF; // R3
          end
        end
      end
      SLP_LIGHT, SLP_DEEP_RUN, SLP_DEEP_OFF: begin
        if (irq_pend) begin
          next_state = SLP_ACTIVE; // R14
        end
      end
      default: next_state = SLP_ACTIVE;
    endcase
  end

  // Outputs registered from the next state so they match the state flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state         <= SLP_ACTIVE;
      sleep_state_o <= 2'b00;
      core_halted_o <= 1'b0;
      hf_clock_on_o <= 1'b1;
    end else begin
      state         <= next_state;
      sleep_state_o <= next_state;
      core_halted_o <= next_state != SLP_ACTIVE;
      hf_clock_on_o <= (next_state == SLP_ACTIVE) || (next_state == SLP_LIGHT); // R1
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence sleep_req_s;
    state == SLP_ACTIVE && wait_for_interrupt_instr_i;
  endsequence
  sequence armed_match_s;
    tick_d && cmp_match && irq_enable[`SLP_IRQ_CMP0];
  endsequence

  // A read of the gated block while either of its clocks is off
  sequence gated_read_s;
    bus_req && !wb_we_i && !mod_clk && (sel_cnt || sel_cmp || sel_ist || sel_ien);
  endsequence

  light_entry_a: assert property (sleep_req_s and !want_deep |=> state == SLP_LIGHT && hf_clock_on_o) // R1
    else $error("light sleep not entered");
  deep_run_a: assert property (sleep_req_s and want_deep && lf_on |=> state == SLP_DEEP_RUN) // R2
    else $error("deep sleep with oscillator not entered");
  deep_stop_a: assert property (sleep_req_s and want_deep && !lf_on |=> state == SLP_DEEP_OFF) // R3
    else $error("deepest sleep not entered");
  debug_limit_a: assert property (sleep_req_s and debug_active_i |=> state == SLP_LIGHT) // R4
    else $error("deep sleep entered in debug");
  deep_clock_a: assert property (sleep_req_s and want_deep |=> !hf_clock_on_o) // R2
    else $error("fast clock kept in deep sleep");
  cmp_flag_a: assert property (tick_d && cmp_match |=> irq_status[`SLP_IRQ_CMP0]) // R7
    else $error("compare flag not set on match");
  tick_gap_a: assert property (lf_tick |=> !lf_tick [*8]) // R8
    else $error("counter tick too fast");
  irq_cause_a: assert property (armed_match_s |=> ##1 irq_o) // R9
    else $error("enabled match gave no interrupt");
  irq_gate_a: assert property (irq_o |-> $past(irq_status & irq_enable) != 2'b00) // R9
    else $error("interrupt without enabled flag");
  // The request lags the flags by a cycle, so a clear shows one cycle later
  irq_hold_a: assert property (irq_o && !$past(wr_icl) && !$past(wr_ien) |=> irq_o) // R11
    else $error("interrupt dropped without clear");
  gated_read_a: assert property (gated_read_s |=> wb_dat_o == 32'h00000000) // R12
    else $error("gated register read returned data");
  clk_gate_a: assert property (bus_wr && sel_cmp && !mod_clk |=> $stable(compare0)) // R12
    else $error("write took effect with clock off");
  top_wrap_a: assert property (lf_tick && cnt_run && next_wrap |=> count == 24'h000000) // R13
    else $error("counter did not wrap at top");
  wake_a: assert property (state != SLP_ACTIVE && irq_pend |=> state == SLP_ACTIVE ##1 irq_o) // R14
    else $error("no wake on interrupt");
endmodule // slp_sleep_ctrl

/* testbench/slp_core_model.sv */
// Core-side partner model: bus master and sleep request source
`timescale 1ns/1ps
module slp_core_model (
  input  wire logic        clk_i,  // Core clock
  input  wire logic [31:0] dat_i,  // Read data
  input  wire logic        ack_i,  // Acknowledge
  output logic             cyc_o,  // Cycle
  output logic             stb_o,  // Strobe
  output logic             we_o,   // Write enable
  output logic      [7:0]  adr_o,  // Byte address
  output logic      [3:0]  sel_o,  // Byte selects
  output logic      [31:0] dat_o,  // Write data
  output logic             wfi_o   // Sleep request pulse
);
  // Idle bus at time zero
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'hff;
    sel_o = 4'h0;
    dat_o = 32'h0;
    wfi_o = 1'b0;
  end

  // Classic cycle; on release address and write data are inverted so stale values never look valid
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    rd = 32'h0;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= we;
    adr_o <= adr;
    sel_o <= 4'hf;
    dat_o <= wd;
    for (n = 0; n < 50 && !ok; n++) begin
      @(posedge clk_i);
      if (ack_i === 1'b1) begin
        ok = 1'b1;
        rd = dat_i;
      end
    end
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~adr;
    dat_o <= ~wd;
  endtask

  // One-cycle sleep instruction
  task automatic sleep;
    @(posedge clk_i);
    wfi_o <= 1'b1;
    @(posedge clk_i);
    wfi_o <= 1'b0;
  endtask
endmodule // slp_core_model

/* testbench/slp_sleep_ctrl_bench.sv */
// Self-checking bench of the sleep controller
`timescale 1ns/1ps
`include "slp_consts.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module slp_sleep_ctrl_bench
  import slp_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, stb, we, ack, wait_for_interrupt_instr, halted, hf_on, irq, irq_q;
  logic        dbg = 1'b0;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  logic [1:0]  state;
  int          failures = 0;
  int          checks = 0;
  int          cyc_n = 0;
  int          rise = 0;
  int          prev_rise = 0;

  // Clock, 40 ns period
  always #20 clk_i = ~clk_i;

  // Interrupt rise times, used for the wake-up period
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    irq_q <= irq;
    if (irq === 1'b1 && irq_q !== 1'b1) begin
      prev_rise <= rise;
      rise      <= cyc_n;
    end
  end

  slp_sleep_ctrl i_slp_sleep_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wait_for_interrupt_instr_i(wait_for_interrupt_instr), .debug_active_i(dbg),
    .sleep_state_o(state), .core_halted_o(halted), .hf_clock_on_o(hf_on), .irq_o(irq));

  slp_core_model i_slp_core_model (.clk_i(clk_i), .dat_i(rdat), .ack_i(ack), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat), .wfi_o(wait_for_interrupt_instr));

  // Verdict and end of run
  task automatic finish_test;
    if (failures == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Bus access; a transfer that never completes ends the run
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    logic ok;
    i_slp_core_model.bus(w, a, d, r, ok);
    if (!ok) begin
      failures++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    `CHK(nm, e, r)
  endtask

  // Bounded wait for the interrupt line, sampled mid-cycle after
  task automatic wait_irq(input int lim);
    int k;
    for (k = 0; k < lim && irq !== 1'b1; k++) begin
      @(posedge clk_i);
    end
    if (irq !== 1'b1) begin
      failures++;
      finish_test();
    end
    @(negedge clk_i);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    int          n, m, k;
    logic [31:0] r;
    logic [1:0]  exp_st;
    void'($urandom(32'h5d9d3dd5));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    `CHK("state", 2'(SLP_ACTIVE), state)
    `CHK("hf_on", 1'b1, hf_on)
    `CHK("irq", 1'b0, irq)
    rd(`SLP_OFS_CTRL, 32'h0, "ctrl");
    wr(`SLP_OFS_COMPARE0, 32'h5);
    wr(`SLP_OFS_CTRL, 32'h68);
    rd(`SLP_OFS_COMPARE0, 32'h0, "gated_cmp");
    rd(8'h1c, 32'h0, "unmapped");
    rd(`SLP_OFS_IRQ_CLEAR, 32'h0, "clear_rd");
    // Oscillator must report stable before deep sleep
    r = 32'h0;
    for (k = 0; k < 400 && r[`SLP_STAT_RCO_RDY] !== 1'b1; k++) begin
      xfer(1'b0, `SLP_OFS_STATUS, 32'h0, r);
    end
    `CHK("rco_rdy", 1'b1, r[`SLP_STAT_RCO_RDY])
    n = 1 + ($urandom % 3);
    wr(`SLP_OFS_COMPARE0, 32'(n));
    wr(`SLP_OFS_IRQ_ENABLE, 32'h1);
    // Light, deep and debug-limited sleep, each woken by the compare match
    for (m = 0; m < 3; m++) begin
      dbg <= (m == 2);
      wr(`SLP_OFS_CTRL, (m > 0) ? 32'h6f : 32'h6b);
      exp_st = (m == 1) ? 2'(SLP_DEEP_RUN) : 2'(SLP_LIGHT);
      i_slp_core_model.sleep();
      @(negedge clk_i);
      `CHK("sleep_state", exp_st, state)
      `CHK("halted", 1'b1, halted)
      `CHK("hf_on", exp_st == 2'(SLP_LIGHT), hf_on)
      wait_irq((n + 2) * 800);
      `CHK("woken", 2'(SLP_ACTIVE), state)
      if (m > 0) begin
        `CHK("period", 1'b1, rise - prev_rise >= (n + 1) * 762 && rise - prev_rise <= (n + 1) * 763)
      end
      rd(`SLP_OFS_COUNT, 32'(n), "count");
      @(negedge clk_i);
      `CHK("irq_held", 1'b1, irq)
      wr(`SLP_OFS_IRQ_CLEAR, 32'h3);
      @(negedge clk_i);
      `CHK("irq_clr", 1'b0, irq)
    end
    dbg <= 1'b0;
    // Flag without enable, then deepest sleep woken by enabling it
    wr(`SLP_OFS_IRQ_ENABLE, 32'h0);
    r = 32'h0;
    for (k = 0; k < 2000 && r[`SLP_IRQ_CMP0] !== 1'b1; k++) begin
      xfer(1'b0, `SLP_OFS_IRQ_STATUS, 32'h0, r);
    end
    @(negedge clk_i);
    `CHK("irq_masked", 1'b0, irq)
    // Without top mode the count runs on past the compare value
    wr(`SLP_OFS_CTRL, 32'h69);
    repeat (1000) @(posedge clk_i);
    rd(`SLP_OFS_COUNT, 32'(n + 1), "count_free");
    wr(`SLP_OFS_CTRL, 32'h67);
    i_slp_core_model.sleep();
    repeat (20) @(negedge clk_i);
    `CHK("deepest", 2'(SLP_DEEP_OFF), state)
    `CHK("hf_off", 1'b0, hf_on)
    wr(`SLP_OFS_IRQ_ENABLE, 32'h1);
    wait_irq(20);
    `CHK("woken3", 2'(SLP_ACTIVE), state)
    rd(`SLP_OFS_IRQ_STATUS, 32'h3, "flags");
    // Gated block: reads give zero and the clear write is lost
    wr(`SLP_OFS_CTRL, 32'h0);
    rd(`SLP_OFS_IRQ_STATUS, 32'h0, "gated_ist");
    wr(`SLP_OFS_IRQ_CLEAR, 32'h3);
    wr(`SLP_OFS_CTRL, 32'h60);
    rd(`SLP_OFS_IRQ_STATUS, 32'h3, "kept_ist");
    finish_test();
  end
endmodule // slp_sleep_ctrl_bench
